/* hdl/sdb_pkg.sv */
/*
  Shared constants for the serial DMA buffer pointer block: register
  offsets, field positions, reset values and the transmit fetch states.
  Assumes a 16-bit register port addressed at the printed offsets.
*/
`default_nettype none

package sdb_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int SDB_AW = 13;
  localparam int SDB_DW = 16;
  localparam int SDB_BW = 8;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [15:0] SDB_RX_A_START_OFS = 16'h4400;
  localparam logic [15:0] SDB_RX_A_END_OFS = 16'h4402;
  localparam logic [15:0] SDB_RX_B_START_OFS = 16'h4404;
  localparam logic [15:0] SDB_RX_B_END_OFS = 16'h4406;
  localparam logic [15:0] SDB_TX_A_START_OFS = 16'h4408;
  localparam logic [15:0] SDB_TX_A_END_OFS = 16'h440A;
  localparam logic [15:0] SDB_TX_B_START_OFS = 16'h440C;
  localparam logic [15:0] SDB_TX_B_END_OFS = 16'h440E;
  localparam logic [15:0] SDB_RX_A_FILL_OFS = 16'h4410;
  localparam logic [15:0] SDB_RX_B_FILL_OFS = 16'h4412;
  localparam logic [15:0] SDB_TX_READ_OFS = 16'h4414;
  localparam logic [15:0] SDB_RX_A_ERR_OFS = 16'h441A;
  localparam logic [15:0] SDB_RX_B_ERR_OFS = 16'h441C;
  localparam logic [15:0] SDB_IRQ_STATUS_OFS = 16'h4420;
  localparam logic [15:0] SDB_IRQ_MASK_OFS = 16'h4422;
  localparam logic [15:0] SDB_CTRL_OFS = 16'h4424;
  localparam logic [15:0] SDB_STATE_OFS = 16'h4426;

  // Address registers in index order: rx A, rx B, tx A, tx B
  localparam int SDB_NCFG = 8;
  localparam logic [15:0] SDB_CFG_OFS [SDB_NCFG] = '{
    SDB_RX_A_START_OFS, SDB_RX_A_END_OFS,
    SDB_RX_B_START_OFS, SDB_RX_B_END_OFS,
    SDB_TX_A_START_OFS, SDB_TX_A_END_OFS,
    SDB_TX_B_START_OFS, SDB_TX_B_END_OFS};

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] SDB_ADDR_TOP = 3'h3;
  localparam logic [2:0] SDB_CNT_TOP = 3'h0;
  localparam logic [12:0] SDB_PTR_RST = 13'h0000;
  localparam logic [12:0] SDB_CFG_RST = 13'h0000;

  // Interrupt events
  localparam int SDB_NEV = 6;
  localparam int SDB_EV_RXA_ULD = 0;
  localparam int SDB_EV_RXB_ULD = 1;
  localparam int SDB_EV_TXA_ULD = 2;
  localparam int SDB_EV_TXB_ULD = 3;
  localparam int SDB_EV_RXA_ERR = 4;
  localparam int SDB_EV_RXB_ERR = 5;

  // Control register bits (write one to act)
  localparam int SDB_CTL_LOAD_RXA = 0;
  localparam int SDB_CTL_LOAD_RXB = 1;
  localparam int SDB_CTL_LOAD_TXA = 2;
  localparam int SDB_CTL_LOAD_TXB = 3;
  localparam int SDB_CTL_RX_RST = 4;
  localparam int SDB_CTL_TX_RST = 5;

  // State register: bits 3:0 loaded rx A, rx B, tx A, tx B
  localparam int SDB_ST_RX_SEL = 4;
  localparam int SDB_ST_TX_SEL = 5;

  typedef enum logic [1:0] {
    SDB_TX_IDLE,
    SDB_TX_READ,
    SDB_TX_WAIT,
    SDB_TX_OFFER
  } sdb_tx_state_t;

endpackage : sdb_pkg

`default_nettype wire

/* hdl/sdb_rx_buf.sv */
/*
  One receive buffer: fill offset, loaded flag and first error capture.
  Assumes wr is raised only while loaded is high, one byte per pulse.
*/
`default_nettype none

module sdb_rx_buf import sdb_pkg::*; #(
  parameter int AW = SDB_AW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] start,
  input wire logic [AW-1:0] end_addr,
  input wire logic load,
  input wire logic dma_rst,
  input wire logic wr,
  input wire logic err,
  output logic loaded,
  output logic [AW-1:0] count,
  output logic [AW-1:0] first_err,
  output logic [AW-1:0] addr,
  output logic unload,
  output logic err_hit
);

  logic armed;
  logic last;

  assign addr = AW'(start + count);
  assign last = addr == end_addr;

  // ------------------------------------------------------------------
  // Fill offset
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= SDB_PTR_RST;
      loaded <= 1'b0;
      unload <= 1'b0;
    end else if (dma_rst) begin
      count <= SDB_PTR_RST;
      loaded <= 1'b0;
      unload <= 1'b0;
    end else begin
      unload <= 1'b0;
      if (wr && loaded) begin
        if (last) begin
          count <= SDB_PTR_RST;
          loaded <= 1'b0;
          unload <= 1'b1;
        end else begin
          count <= AW'(count + 1'b1);
        end
      end else if (load) begin
        loaded <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // First error capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b1;
      first_err <= SDB_PTR_RST;
      err_hit <= 1'b0;
    end else if (dma_rst) begin
      armed <= 1'b1;
      first_err <= SDB_PTR_RST;
      err_hit <= 1'b0;
    end else begin
      err_hit <= 1'b0;
      if (load && !loaded) begin
        armed <= 1'b1;
        first_err <= SDB_PTR_RST;
      end else if (wr && loaded && err && armed) begin
        first_err <= count;
        armed <= 1'b0;
        err_hit <= 1'b1;
      end
    end
  end

endmodule : sdb_rx_buf

`default_nettype wire

/* hdl/sdb_irq.sv */
/*
  Sticky event status with write-one-to-clear, a mask and one level
  interrupt. Assumes events are one-cycle pulses on the same clock.
*/
`default_nettype none

module sdb_irq import sdb_pkg::*; #(
  parameter int N = SDB_NEV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] event_in,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  // A new event beats a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clr_wr ? wdata : '0)) | event_in;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask <= '0;
    end else if (mask_wr) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status_m());
    end
  end

  function automatic logic [N-1:0] next_status_m();
    next_status_m = status & mask;
  endfunction : next_status_m

endmodule : sdb_irq

`default_nettype wire

/* hdl/sdb_dma_pointers.sv */
/*
  Pointer logic of a double-buffered serial DMA: address registers,
  receive fill offsets, transmit read offset, first error capture,
  a receive byte path into RAM and a transmit fetch path out of RAM.
  Assumes the FIFO and RAM sit on clk; RAM read data arrive one cycle
  after the read strobe.
*/
`default_nettype none

module sdb_dma_pointers import sdb_pkg::*; #(
  parameter int AW = SDB_AW,
  parameter int BW = SDB_BW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [SDB_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SDB_DW-1:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [BW-1:0] rx_data,
  input wire logic rx_err,
  output logic rx_ready,
  output logic ram_wr,
  output logic [AW-1:0] ram_waddr,
  output logic [BW-1:0] ram_wdata,
  output logic ram_rd,
  output logic [AW-1:0] ram_raddr,
  input wire logic [BW-1:0] ram_rdata,
  output logic tx_valid,
  output logic [BW-1:0] tx_data,
  input wire logic tx_ready,
  output logic irq
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [AW-1:0] cfg [SDB_NCFG];
  logic ctrl_wr;
  logic [1:0] rx_load;
  logic [1:0] tx_load;
  logic rx_rst;
  logic tx_rst;
  logic [1:0] rx_loaded;
  logic [1:0] rx_wr;
  logic [AW-1:0] rx_count [2];
  logic [AW-1:0] rx_first_err [2];
  logic [AW-1:0] rx_addr [2];
  logic [1:0] rx_unload;
  logic [1:0] rx_err_hit;
  logic rx_sel;
  logic rx_take;
  logic tx_sel;
  logic [1:0] tx_loaded;
  logic [AW-1:0] tx_count;
  logic [AW-1:0] tx_start;
  logic [AW-1:0] tx_end;
  logic [AW-1:0] tx_addr;
  logic [1:0] tx_unload;
  logic tx_take;
  logic tx_last;
  logic tx_fetch;
  sdb_tx_state_t tx_state;
  logic [SDB_NEV-1:0] irq_event;
  logic [SDB_NEV-1:0] irq_status;
  logic [SDB_NEV-1:0] irq_mask;
  logic [SDB_DW-1:0] next_rdata;

  // ------------------------------------------------------------------
  // Address registers
  // ------------------------------------------------------------------
  // Only the low 13 bits are stored; the fixed top bits are read-side.
  for (genvar i = 0; i < SDB_NCFG; i++) begin : g_cfg
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        cfg[i] <= SDB_CFG_RST;
      end else if (reg_wr && reg_addr == SDB_CFG_OFS[i]) begin
        cfg[i] <= reg_wdata[AW-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Control strobes
  // ------------------------------------------------------------------
  assign ctrl_wr = reg_wr && reg_addr == SDB_CTRL_OFS;
  assign rx_load[0] = ctrl_wr && reg_wdata[SDB_CTL_LOAD_RXA];
  assign rx_load[1] = ctrl_wr && reg_wdata[SDB_CTL_LOAD_RXB];
  assign tx_load[0] = ctrl_wr && reg_wdata[SDB_CTL_LOAD_TXA];
  assign tx_load[1] = ctrl_wr && reg_wdata[SDB_CTL_LOAD_TXB];
  assign rx_rst = ctrl_wr && reg_wdata[SDB_CTL_RX_RST];
  assign tx_rst = ctrl_wr && reg_wdata[SDB_CTL_TX_RST];

  // ------------------------------------------------------------------
  // Receive buffers
  // ------------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_rx
    sdb_rx_buf #(
      .AW(AW)
    ) u_buf (
      .clk(clk),
      .rstn(rstn),
      .start(cfg[2*b]),
      .end_addr(cfg[2*b+1]),
      .load(rx_load[b]),
      .dma_rst(rx_rst),
      .wr(rx_wr[b]),
      .err(rx_err),
      .loaded(rx_loaded[b]),
      .count(rx_count[b]),
      .first_err(rx_first_err[b]),
      .addr(rx_addr[b]),
      .unload(rx_unload[b]),
      .err_hit(rx_err_hit[b])
    );
    assign rx_wr[b] = rx_take && (rx_sel == 1'(b));
  end

  // Stall the FIFO whenever the selected buffer is not loaded
  assign rx_ready = rx_loaded[rx_sel];
  assign rx_take = rx_valid && rx_ready;

  // Hand over to the other buffer once the current one stops taking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sel <= 1'b0;
    end else if (rx_rst) begin
      rx_sel <= 1'b0;
    end else if (rx_take && rx_addr[rx_sel] == cfg[2*rx_sel+1]) begin
      rx_sel <= ~rx_sel;
    end else if (!rx_loaded[rx_sel] && rx_loaded[~rx_sel]) begin
      rx_sel <= ~rx_sel;
    end
  end

  // Registered RAM write: the byte lands one cycle after acceptance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_wr <= 1'b0;
      ram_waddr <= SDB_PTR_RST;
      ram_wdata <= '0;
    end else begin
      ram_wr <= rx_take;
      if (rx_take) begin
        ram_waddr <= rx_addr[rx_sel];
        ram_wdata <= rx_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit pointer
  // ------------------------------------------------------------------
  assign tx_start = tx_sel ? cfg[6] : cfg[4];
  assign tx_end = tx_sel ? cfg[7] : cfg[5];
  assign tx_addr = AW'(tx_start + tx_count);
  assign tx_take = tx_valid && tx_ready;
  assign tx_last = tx_take && tx_addr == tx_end;
  assign tx_fetch = tx_state == SDB_TX_IDLE && tx_loaded[tx_sel];

  // Loaded flags; a taken end byte unloads the buffer it came from
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_loaded <= 2'h0;
      tx_unload <= 2'h0;
    end else if (tx_rst) begin
      tx_loaded <= 2'h0;
      tx_unload <= 2'h0;
    end else begin
      tx_unload <= 2'h0;
      tx_loaded <= tx_loaded | tx_load;
      if (tx_last) begin
        tx_loaded[tx_sel] <= 1'b0;
        tx_unload[tx_sel] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_count <= SDB_PTR_RST;
    end else if (tx_rst || tx_last) begin
      tx_count <= SDB_PTR_RST;
    end else if (tx_take) begin
      tx_count <= AW'(tx_count + 1'b1);
    end
  end

  // Switch only between bytes, so a fetch in flight keeps its buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sel <= 1'b0;
    end else if (tx_rst) begin
      tx_sel <= 1'b0;
    end else if (tx_last) begin
      tx_sel <= ~tx_sel;
    end else if (tx_state == SDB_TX_IDLE && !tx_loaded[tx_sel]
                 && tx_loaded[~tx_sel]) begin
      tx_sel <= ~tx_sel;
    end
  end

  // ------------------------------------------------------------------
  // Transmit fetch
  // ------------------------------------------------------------------
  // One byte in flight at a time: simple, and the FIFO rate is far
  // below four clock cycles per byte.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= SDB_TX_IDLE;
    end else if (tx_rst) begin
      tx_state <= SDB_TX_IDLE;
    end else begin
      unique case (tx_state)
        SDB_TX_IDLE: begin
          if (tx_fetch) begin
            tx_state <= SDB_TX_READ;
          end
        end
        SDB_TX_READ: begin
          tx_state <= SDB_TX_WAIT;
        end
        SDB_TX_WAIT: begin
          tx_state <= SDB_TX_OFFER;
        end
        SDB_TX_OFFER: begin
          if (tx_ready) begin
            tx_state <= SDB_TX_IDLE;
          end
        end
      endcase
    end
  end

  // The read address stands until the next fetch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_rd <= 1'b0;
      ram_raddr <= SDB_PTR_RST;
    end else if (tx_rst) begin
      ram_rd <= 1'b0;
    end else begin
      ram_rd <= tx_fetch;
      if (tx_fetch) begin
        ram_raddr <= tx_addr;
      end
    end
  end

  // RAM data are taken the cycle after the read and held until taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (tx_rst) begin
      tx_valid <= 1'b0;
    end else if (tx_state == SDB_TX_WAIT) begin
      tx_data <= ram_rdata;
      tx_valid <= 1'b1;
    end else if (tx_take) begin
      tx_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  assign irq_event[SDB_EV_RXA_ULD] = rx_unload[0];
  assign irq_event[SDB_EV_RXB_ULD] = rx_unload[1];
  assign irq_event[SDB_EV_TXA_ULD] = tx_unload[0];
  assign irq_event[SDB_EV_TXB_ULD] = tx_unload[1];
  assign irq_event[SDB_EV_RXA_ERR] = rx_err_hit[0];
  assign irq_event[SDB_EV_RXB_ERR] = rx_err_hit[1];

  sdb_irq #(
    .N(SDB_NEV)
  ) u_irq (
    .clk(clk),
    .rstn(rstn),
    .event_in(irq_event),
    .clr_wr(reg_wr && reg_addr == SDB_IRQ_STATUS_OFS),
    .mask_wr(reg_wr && reg_addr == SDB_IRQ_MASK_OFS),
    .wdata(reg_wdata[SDB_NEV-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ------------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------------
  // Offset registers have no write path at all, so writes are ignored.
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < SDB_NCFG; i++) begin
      if (reg_addr == SDB_CFG_OFS[i]) begin
        next_rdata = {1'b0, SDB_ADDR_TOP[1:0], cfg[i]};
      end
    end
    unique case (reg_addr)
      SDB_RX_A_FILL_OFS: next_rdata = {SDB_CNT_TOP, rx_count[0]};
      SDB_RX_B_FILL_OFS: next_rdata = {SDB_CNT_TOP, rx_count[1]};
      SDB_TX_READ_OFS: next_rdata = {SDB_CNT_TOP, tx_count};
      SDB_RX_A_ERR_OFS: next_rdata = {SDB_CNT_TOP, rx_first_err[0]};
      SDB_RX_B_ERR_OFS: next_rdata = {SDB_CNT_TOP, rx_first_err[1]};
      SDB_IRQ_STATUS_OFS: next_rdata = 16'(irq_status);
      SDB_IRQ_MASK_OFS: next_rdata = 16'(irq_mask);
      SDB_STATE_OFS: begin
        next_rdata[3:0] = {tx_loaded, rx_loaded};
        next_rdata[SDB_ST_RX_SEL] = rx_sel;
        next_rdata[SDB_ST_TX_SEL] = tx_sel;
      end
      default: begin
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

endmodule : sdb_dma_pointers

`default_nettype wire

/* tb/sdb_dma_pointers_asserts.sv */
/*
  Port checker for the serial DMA pointer block.
  Assumes one clock, active-low async reset, FIFO and RAM on clk.
*/
`default_nettype none

module sdb_chk import sdb_pkg::*; #(
  parameter int AW = SDB_AW,
  parameter int BW = SDB_BW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [SDB_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [SDB_DW-1:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [BW-1:0] rx_data,
  input wire logic rx_err,
  input wire logic rx_ready,
  input wire logic ram_wr,
  input wire logic [AW-1:0] ram_waddr,
  input wire logic [BW-1:0] ram_wdata,
  input wire logic ram_rd,
  input wire logic [AW-1:0] ram_raddr,
  input wire logic [BW-1:0] ram_rdata,
  input wire logic tx_valid,
  input wire logic [BW-1:0] tx_data,
  input wire logic tx_ready,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take;
    rx_valid && rx_ready;
  endsequence

  sequence s_fetch;
    ram_rd;
  endsequence

  property p_fetch;
    logic [BW-1:0] d;
    s_fetch |=> (1'b1, d = ram_rdata) ##1 (tx_valid && tx_data == d);
  endproperty

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_rx_write: assert property (s_take |=> ram_wr &&
    ram_wdata == $past(rx_data)) else $error("taken byte not written");
  a_no_stray_wr: assert property (!(rx_valid && rx_ready) |=> !ram_wr)
    else $error("RAM write without a taken byte");
  a_rd_single: assert property (ram_rd |=> !ram_rd [*3])
    else $error("RAM reads closer than four cycles");
  a_tx_fetch: assert property (p_fetch)
    else $error("fetched byte not offered two cycles later");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("offered byte dropped");
  a_tx_drop: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("offer stays after acceptance");
  a_addr_top: assert property (reg_rd && reg_addr == SDB_RX_A_START_OFS
    |=> reg_rdata[15:13] == SDB_ADDR_TOP) else $error("address top bits");
  a_cnt_top: assert property (reg_rd && reg_addr == SDB_RX_A_FILL_OFS
    |=> reg_rdata[15:13] == SDB_CNT_TOP) else $error("offset top bits");
endmodule : sdb_chk

bind sdb_dma_pointers sdb_chk #(.AW(AW), .BW(BW)) i_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
  .rx_ready(rx_ready), .ram_wr(ram_wr), .ram_waddr(ram_waddr),
  .ram_wdata(ram_wdata), .ram_rd(ram_rd), .ram_raddr(ram_raddr),
  .ram_rdata(ram_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .irq(irq));

`default_nettype wire

/* tb/sdb_far_model.sv */
/*
  Far side model: byte RAM with one-cycle read latency and a FIFO
  sink that can stall. Assumes the same clk as the block.
*/
`default_nettype none

module sdb_far_model (
  input wire logic clk,
  input wire logic ram_wr,
  input wire logic [12:0] ram_waddr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_rd,
  input wire logic [12:0] ram_raddr,
  output logic [7:0] ram_rdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Storage and sink
  // ------------------------------------------------------------------
  logic [7:0] mem [8192];
  logic [7:0] txq [$];
  logic [1:0] cnt = 2'h0;
  initial ram_rdata = 8'h00;
  assign tx_ready = !slow || cnt == 2'h3;
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    if (ram_wr) mem[ram_waddr] <= ram_wdata;
    // Data only valid the cycle after a read; toggled otherwise
    if (ram_rd) ram_rdata <= mem[ram_raddr];
    else ram_rdata <= ~ram_rdata;
    if (tx_valid && tx_ready) txq.push_back(tx_data);
  end
endmodule : sdb_far_model

`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the serial DMA pointer block.
  Assumes the far side model and the port checker are compiled.
*/
`default_nettype none

module tb_top import sdb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_err = 1'b0;
  logic [15:0] reg_rdata;
  logic rx_ready, ram_wr, ram_rd, tx_valid, tx_ready, irq;
  logic [12:0] ram_waddr, ram_raddr;
  logic [7:0] ram_wdata, ram_rdata, tx_data;
  int err_total = 0;
  int compares = 0;
  localparam logic [15:0] RO_OFS [5] = '{SDB_RX_A_FILL_OFS,
    SDB_RX_B_FILL_OFS, SDB_TX_READ_OFS, SDB_RX_A_ERR_OFS, SDB_RX_B_ERR_OFS};

  always #20 clk = ~clk;

  sdb_dma_pointers i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .rx_ready(rx_ready), .ram_wr(ram_wr),
    .ram_waddr(ram_waddr), .ram_wdata(ram_wdata), .ram_rd(ram_rd),
    .ram_raddr(ram_raddr), .ram_rdata(ram_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .irq(irq));

  sdb_far_model p (.clk(clk), .ram_wr(ram_wr), .ram_waddr(ram_waddr),
    .ram_wdata(ram_wdata), .ram_rd(ram_rd), .ram_raddr(ram_raddr),
    .ram_rdata(ram_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .slow(1'b1));

  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // Bytes follow back to back; each held until rx_ready is sampled high
  task automatic burst(input logic [7:0] d0, input int n,
                       input logic [7:0] em);
    int w;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_data <= d0 + 8'(i);
      rx_err <= em[i];
      rx_valid <= 1'b1;
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (rx_ready !== 1'b1 && w < 50);
      if (w >= 50) begin
        err_total++;
        conclude();
      end
    end
    rx_valid <= 1'b0;
  endtask : burst

  task automatic wait_tx(input int n);
    int w;
    w = 0;
    while (p.txq.size() < n && w < 200) begin
      @(posedge clk);
      #1 w++;
    end
    if (w >= 200) begin
      err_total++;
      conclude();
    end
  endtask : wait_tx

  task automatic irq_is(input logic [15:0] exp);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, irq}, exp);
  endtask : irq_is

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (SDB_CFG_OFS[i]) rd(SDB_CFG_OFS[i], 16'h6000);
    foreach (RO_OFS[i]) begin
      rd(RO_OFS[i], 16'h0000);
      wr(RO_OFS[i], 16'hFFFF);
      rd(RO_OFS[i], 16'h0000);
    end
    rd(16'h4416, 16'h0000);
    foreach (SDB_CFG_OFS[i]) begin
      wr(SDB_CFG_OFS[i], 16'hFFFF);
      rd(SDB_CFG_OFS[i], 16'h7FFF);
    end
    $display("test registers done");
    wr(SDB_RX_A_START_OFS, 16'h0100);
    wr(SDB_RX_A_END_OFS, 16'h0103);
    wr(SDB_RX_B_START_OFS, 16'h0200);
    wr(SDB_RX_B_END_OFS, 16'h0201);
    wr(SDB_CTRL_OFS, 16'h0003);
    burst(8'hA0, 2, 8'h00);
    rd(SDB_RX_A_FILL_OFS, 16'h0002);
    burst(8'hA2, 3, 8'h03);
    rd(SDB_RX_A_FILL_OFS, 16'h0000);
    rd(SDB_RX_A_ERR_OFS, 16'h0002);
    rd(SDB_RX_B_FILL_OFS, 16'h0001);
    rd(SDB_RX_B_ERR_OFS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      chk(p.mem[13'h0100 + 13'(i)], 16'h00A0 + 16'(i));
    end
    chk(p.mem[13'h0200], 16'h00A4);
    rd(SDB_IRQ_STATUS_OFS, 16'h0011);
    wr(SDB_IRQ_MASK_OFS, 16'h0001);
    irq_is(16'h0001);
    wr(SDB_IRQ_STATUS_OFS, 16'h0001);
    irq_is(16'h0000);
    wr(SDB_CTRL_OFS, 16'h0001);
    rd(SDB_RX_A_ERR_OFS, 16'h0000);
    burst(8'hB0, 3, 8'h04);
    rd(SDB_RX_B_FILL_OFS, 16'h0000);
    rd(SDB_RX_A_FILL_OFS, 16'h0002);
    rd(SDB_RX_A_ERR_OFS, 16'h0001);
    wr(SDB_CTRL_OFS, 16'h0010);
    rd(SDB_RX_A_ERR_OFS, 16'h0000);
    $display("test receive done");
    wr(SDB_TX_A_START_OFS, 16'h0101);
    wr(SDB_TX_A_END_OFS, 16'h0102);
    wr(SDB_CTRL_OFS, 16'h0004);
    wait_tx(1);
    rd(SDB_TX_READ_OFS, 16'h0001);
    wait_tx(2);
    rd(SDB_TX_READ_OFS, 16'h0000);
    chk({8'h00, p.txq[0]}, 16'h00B2);
    chk({8'h00, p.txq[1]}, 16'h00A2);
    wr(SDB_IRQ_MASK_OFS, 16'h0004);
    irq_is(16'h0001);
    wr(SDB_IRQ_STATUS_OFS, 16'h0004);
    irq_is(16'h0000);
    rd(SDB_STATE_OFS, 16'h0020);
    wr(SDB_CTRL_OFS, 16'h0020);
    rd(SDB_STATE_OFS, 16'h0000);
    $display("test transmit done");
    conclude();
  end
endmodule : tb_top

`default_nettype wire
